//--- dv/nested_priority_interrupt_controller_tb.sv
// testbench of the interrupt controller: apb registers and core entry
// assumes npic_pkg, npic_ctrl and npic_core_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module nested_priority_interrupt_controller_tb;
   logic                     pclk, presetn, psel, penable, pwrite;
   logic                     pready, pslverr, er, ack;
   logic [7:0]               paddr;
   logic [31:0]              pwdata, prdata, rd;
   logic [16:0]              cv;
   logic [1:0]               dly;
   logic [13:0]              pf, pe, pc;
   logic [15:0]              ep, es;
   npic_pkg::npic_core_in_t  ci;
   npic_pkg::npic_core_out_t co;
   int                       n_mismatch, total_checks;
   // rows: address, write data, expected read
   logic [47:0] rows [6] = '{
      {npic_pkg::ADDR_ISPR0, 32'h64, 8'h74},
      {npic_pkg::ADDR_ISPR1, 32'h00, 8'h00},
      {npic_pkg::ADDR_ISPR2, 32'hC1, 8'hC1},
      {npic_pkg::ADDR_ISPR3, 32'h00, 8'hF0},
      {npic_pkg::ADDR_SENS,  32'h55, 8'h55},
      {npic_pkg::ADDR_CC,    32'h00, 8'hEA}};
   assign ci = npic_pkg::npic_core_in_t'({cv[16], ack, cv[14:9], cv[7:0]});
   npic_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_i(ci),
      .core_o(co), .periph_flag(pf), .periph_en(pe), .periph_clr(pc),
      .ext_pin(ep), .ext_sel(es));
   npic_core_model core (.pclk(pclk), .presetn(presetn),
      .stack_req(co.stack_req), .ack_dly(dly), .stack_ack(ack));
   // ==================================================
   // helpers
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task pul(input int b);
      @(posedge pclk);
      cv[b] <= 1'b1;
      @(posedge pclk);
      cv[b] <= 1'b0;
   endtask : pul
   task svc(input logic ie, input logic [15:0] va, input logic [7:0] c);
      int k;
      k = 0;
      if (ie) pul(16);
      do begin
         @(posedge pclk);
         #1;
         k++;
      end while (co.vec_load !== 1'b1 && k < 30);
      chk({16'h0, co.vec_addr}, {16'h0, va});
      @(posedge pclk);
      #1;
      chk({24'h0, co.cc}, {24'h0, c});
   endtask : svc
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   // ==================================================
   // clock, watchdog, sequence
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #20000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      cv = {9'h0, 8'hE2};
      {dly, pf, pc, ep} = '0;
      pe = 14'h3FFF;
      es = 16'h0003;
      repeat (2) @(posedge pclk);
      #1;
      chk({16'h0, co.vec_addr}, 32'hFFFE);
      chk({24'h0, co.cc}, 32'hEA);
      @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'hFF);
      end
      $display("reset done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i][47:40], rows[i][39:8]);
         apb(1'b0, rows[i][47:40], 32'h0);
         chk(rd, {24'h0, rows[i][7:0]});
      end
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("registers done");
      pul(13);
      #1;
      chk({24'h0, co.cc}, 32'hE2);
      @(posedge pclk);
      pf <= 14'h0700;
      svc(1'b1, 16'hFFE8, 8'hC2);
      pul(16);
      #1;
      chk({31'h0, co.stack_req}, 32'h0);
      @(posedge pclk);
      pf[9] <= 1'b0;
      pc[9] <= 1'b1;
      dly <= 2'h3;
      @(posedge pclk);
      pc[9] <= 1'b0;
      pul(9);
      #1;
      chk({24'h0, co.cc}, 32'hE2);
      svc(1'b1, 16'hFFE6, 8'hC2);
      $display("nesting done");
      pul(12);
      #1;
      chk({24'h0, co.cc}, 32'hEA);
      pul(14);
      svc(1'b1, 16'hFFFC, 8'hEA);
      $display("trap done");
      pul(11);
      repeat (5) @(posedge pclk);
      #1;
      chk({31'h0, co.halted}, 32'h1);
      chk({24'h0, co.cc}, 32'hE2);
      @(posedge pclk);
      ep[1] <= 1'b1;
      svc(1'b0, 16'hFFF6, 8'hEA);
      apb(1'b0, npic_pkg::ADDR_PEND, 32'h0);
      chk(rd, 32'h500);
      $display("halt done");
      pul(10);
      svc(1'b0, 16'hFFE6, 8'hC2);
      $display("wait done");
      print_verdict();
   end
endmodule : nested_priority_interrupt_controller_tb
`default_nettype wire

//--- dv/npic_core_model.sv
// core-side model: pushes context on request, acknowledges after a delay
// assumes stack_req comes from the controller on pclk
`timescale 1ns/1ns
`default_nettype none
module npic_core_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       stack_req,
   input  wire logic [1:0] ack_dly,
   output var  logic       stack_ack
);
   logic [2:0] cnt_reg;
   // ==================================================
   // push pc, x, a, cc; nesting depth is never checked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 3'h0;
      end else if (stack_req) begin
         cnt_reg <= cnt_reg + 3'h1;
      end else begin
         cnt_reg <= 3'h0;
      end
   end
   // ack only while requested, prompt or slow
   assign stack_ack = stack_req && (cnt_reg == {1'b0, ack_dly});
endmodule : npic_core_model
`default_nettype wire

//--- hdl/npic_ctrl.sv
// nested priority interrupt controller with apb register slave
// assumes core_i comes from core logic on pclk; ext_pin is asynchronous
`timescale 1ns/1ns
`default_nettype none
module npic_ctrl #(
   parameter int            NV  = npic_pkg::NUM_VEC,
   parameter int            NL  = npic_pkg::EXT_LINES,
   parameter int            NP  = npic_pkg::EXT_PINS,
   parameter logic [13:0]   HWM = npic_pkg::HALT_WAKE
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic [7:0]             paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output var  logic [31:0]            prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   input  wire npic_pkg::npic_core_in_t core_i,
   output var  npic_pkg::npic_core_out_t core_o,
   input  wire logic [NV-1:0]          periph_flag,
   input  wire logic [NV-1:0]          periph_en,
   input  wire logic [NV-1:0]          periph_clr,
   input  wire logic [NL*NP-1:0]       ext_pin,
   input  wire logic [NL*NP-1:0]       ext_sel
);
   // ======================================================
   // declarations
   npic_pkg::npic_state_t state_reg;
   npic_pkg::npic_state_t state_next;
   logic [7:0]       ispr_reg [4];
   logic [7:0]       sens_reg;
   logic [7:0]       cc_reg;
   logic [NV-1:0]    pend_reg;
   logic             trap_reg;
   logic [NL*NP-1:0] sync1_reg;
   logic [NL*NP-1:0] sync2_reg;
   logic [NL-1:0]    line_prev_reg;
   logic [NL-1:0]    line_lvl;
   logic [NL-1:0]    ext_evt;
   logic [NL-1:0]    sens_chg;
   logic [15:0]      vec_addr_reg;
   logic             sel_nm_reg;
   logic [3:0]       sel_idx_reg;
   logic [31:0]      prdata_reg;
   logic             pslverr_reg;
   logic [31:0]      ispr_flat;
   logic [1:0]       cur_lvl;
   logic [NV-1:0]    elig;
   logic             win_found;
   logic [3:0]       win_idx;
   logic [1:0]       win_lvl;
   logic             any_pend;
   logic             wr_en;
   logic             setup;
   logic             entry;

   assign ispr_flat = {ispr_reg[3], ispr_reg[2], ispr_reg[1], ispr_reg[0]};
   assign cur_lvl = npic_pkg::npic_lvl({cc_reg[npic_pkg::CC_I1],
                                        cc_reg[npic_pkg::CC_I0]});
   assign wr_en = psel && penable && pwrite;
   assign setup = psel && !penable;
   assign entry = (state_reg == npic_pkg::ST_VECT);

   // ======================================================
   // external line synchroniser and edge or low-level detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg     <= '0;
         sync2_reg     <= '0;
         line_prev_reg <= '0;
      end else begin
         sync1_reg     <= ext_pin;
         sync2_reg     <= sync1_reg;
         line_prev_reg <= line_lvl;
      end
   end

   genvar l;
   generate
      for (l = 0; l < NL; l++) begin : g_line
         logic [1:0] s;
         assign s = sens_reg[2*l+:2];
         assign line_lvl[l] = |(sync2_reg[l*NP+:NP] & ext_sel[l*NP+:NP]);
         always_comb begin
            case (s)
               npic_pkg::SENS_RISE: ext_evt[l] = line_lvl[l] && !line_prev_reg[l];
               npic_pkg::SENS_FALL: ext_evt[l] = !line_lvl[l] && line_prev_reg[l];
               npic_pkg::SENS_BOTH: ext_evt[l] = line_lvl[l] != line_prev_reg[l];
               default:             ext_evt[l] = !line_lvl[l];
            endcase
         end
         assign sens_chg[l] = wr_en && (paddr == npic_pkg::ADDR_SENS) &&
                              (pwdata[2*l+:2] != s);
      end
   endgenerate

   // ======================================================
   // pending latches, set wins over clear
   genvar v;
   generate
      for (v = 0; v < NV; v++) begin : g_pend
         logic set_c;
         logic clr_c;
         if (v >= npic_pkg::EXT_BASE && v < npic_pkg::EXT_BASE + NL) begin : g_ext
            // an event seen under the old sensitivity dies with the rewrite
            assign set_c = ext_evt[v-npic_pkg::EXT_BASE] &&
                           !sens_chg[v-npic_pkg::EXT_BASE];
            assign clr_c = (entry && !sel_nm_reg && sel_idx_reg == v) ||
                           sens_chg[v-npic_pkg::EXT_BASE];
         end else begin : g_per
            assign set_c = periph_flag[v] && periph_en[v];
            assign clr_c = periph_clr[v];
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pend_reg[v] <= 1'b0;
            end else if (set_c) begin
               pend_reg[v] <= 1'b1;
            end else if (clr_c) begin
               pend_reg[v] <= 1'b0;
            end
         end
      end
   endgenerate

   // trap latch, served once per trap instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_reg <= 1'b0;
      end else if (core_i.trap) begin
         trap_reg <= 1'b1;
      end else if (entry && sel_nm_reg) begin
         trap_reg <= 1'b0;
      end
   end

   // ======================================================
   // arbitration
   assign elig = (state_reg == npic_pkg::ST_HALT) ? (pend_reg & HWM)
                                                  : pend_reg;

   always_comb begin
      logic [1:0] lv;
      lv        = 2'b00;
      win_found = 1'b0;
      win_idx   = 4'h0;
      win_lvl   = 2'b00;
      // downward scan with >= so the lower index wins ties
      for (int i = NV - 1; i >= 0; i--) begin
         lv = npic_pkg::npic_lvl(ispr_flat[2*i+:2]);
         if (elig[i] && lv > cur_lvl && (!win_found || lv >= win_lvl)) begin
            win_found = 1'b1;
            win_idx   = i[3:0];
            win_lvl   = lv;
         end
      end
   end

   assign any_pend = trap_reg || win_found;

   // ======================================================
   // sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         npic_pkg::ST_RSTV: state_next = npic_pkg::ST_RUN;
         npic_pkg::ST_RUN: begin
            if (core_i.halt) begin
               state_next = npic_pkg::ST_HALT;
            end else if (core_i.wait_for_irq_instr) begin
               state_next = npic_pkg::ST_WAIT;
            end else if (core_i.instr_end && any_pend) begin
               state_next = npic_pkg::ST_STACK;
            end
         end
         npic_pkg::ST_HALT,
         npic_pkg::ST_WAIT: begin
            if (any_pend) begin
               state_next = npic_pkg::ST_STACK;
            end
         end
         npic_pkg::ST_STACK: begin
            if (core_i.stack_ack) begin
               state_next = npic_pkg::ST_VECT;
            end
         end
         npic_pkg::ST_VECT: state_next = npic_pkg::ST_RUN;
         default:           state_next = npic_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= npic_pkg::ST_RSTV;
      end else begin
         state_reg <= state_next;
      end
   end

   // selection captured when stacking starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_nm_reg   <= 1'b0;
         sel_idx_reg  <= 4'h0;
         vec_addr_reg <= npic_pkg::VEC_RESET;
      end else if (state_next == npic_pkg::ST_STACK &&
                   state_reg != npic_pkg::ST_STACK) begin
         sel_nm_reg  <= trap_reg;
         sel_idx_reg <= win_idx;
         vec_addr_reg <= trap_reg ? npic_pkg::VEC_TRAP :
                         npic_pkg::VEC_BASE - {11'h000, win_idx, 1'b0};
      end
   end

   // ======================================================
   // condition code register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_reg <= npic_pkg::CC_RST;
      end else if (entry) begin
         if (sel_nm_reg) begin
            cc_reg[npic_pkg::CC_I1] <= 1'b1;
            cc_reg[npic_pkg::CC_I0] <= 1'b1;
         end else begin
            cc_reg[npic_pkg::CC_I1] <= ispr_flat[2*sel_idx_reg+1];
            cc_reg[npic_pkg::CC_I0] <= ispr_flat[2*sel_idx_reg];
         end
      end else if (core_i.cc_wr) begin
         cc_reg <= core_i.cc_wdata | npic_pkg::CC_FIXED;
      end else if (core_i.sim) begin
         cc_reg[npic_pkg::CC_I1] <= npic_pkg::PRIO_L3[1];
         cc_reg[npic_pkg::CC_I0] <= npic_pkg::PRIO_L3[0];
      end else if (core_i.irq_enable_instr || core_i.halt || core_i.wait_for_irq_instr) begin
         cc_reg[npic_pkg::CC_I1] <= npic_pkg::PRIO_L0[1];
         cc_reg[npic_pkg::CC_I0] <= npic_pkg::PRIO_L0[0];
      end
   end

   // ======================================================
   // apb registers
   genvar r;
   generate
      for (r = 0; r < 4; r++) begin : g_ispr
         logic [7:0] nv;
         always_comb begin
            nv = ispr_reg[r];
            for (int f = 0; f < 4; f++) begin
               if (pwdata[2*f+:2] != npic_pkg::PRIO_L0) begin
                  nv[2*f+:2] = pwdata[2*f+:2];
               end
            end
            if (r == 3) begin
               nv = nv | npic_pkg::ISPR3_RO;
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ispr_reg[r] <= npic_pkg::ISPR_RST;
            end else if (wr_en &&
                         paddr == npic_pkg::ADDR_ISPR0 + 8'(4 * r)) begin
               ispr_reg[r] <= nv;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sens_reg <= npic_pkg::SENS_RST;
      end else if (wr_en && paddr == npic_pkg::ADDR_SENS) begin
         sens_reg <= pwdata[7:0];
      end
   end

   // read data and error registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
         case (paddr)
            npic_pkg::ADDR_ISPR0: prdata_reg[7:0] <= ispr_reg[0];
            npic_pkg::ADDR_ISPR1: prdata_reg[7:0] <= ispr_reg[1];
            npic_pkg::ADDR_ISPR2: prdata_reg[7:0] <= ispr_reg[2];
            npic_pkg::ADDR_ISPR3: prdata_reg[7:0] <= ispr_reg[3];
            npic_pkg::ADDR_SENS:  prdata_reg[7:0] <= sens_reg;
            npic_pkg::ADDR_CC:    prdata_reg[7:0] <= cc_reg;
            npic_pkg::ADDR_PEND:  prdata_reg[NV:0] <= {trap_reg, pend_reg};
            default:              pslverr_reg <= 1'b1;
         endcase
      end
   end

   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;
   assign pready  = 1'b1;

   assign core_o.stack_req = (state_reg == npic_pkg::ST_STACK);
   assign core_o.vec_load  = entry || (state_reg == npic_pkg::ST_RSTV);
   assign core_o.vec_addr  = vec_addr_reg;
   assign core_o.halted    = (state_reg == npic_pkg::ST_HALT);
   assign core_o.waiting   = (state_reg == npic_pkg::ST_WAIT);
   assign core_o.cc        = cc_reg;

   // ======================================================
   // assertions
   property p_rst_cc;
      @(posedge pclk) disable iff (!presetn)
      state_reg == npic_pkg::ST_RSTV |-> cc_reg[7:6] == 2'b11 &&
         cc_reg[npic_pkg::CC_I1] && cc_reg[npic_pkg::CC_I0] &&
         vec_addr_reg == npic_pkg::VEC_RESET;
   endproperty
   a_rst_cc: assert property (p_rst_cc)
      else $error("cc or vector wrong in reset fetch");

   property p_entry_lvl;
      @(posedge pclk) disable iff (!presetn)
      entry && !sel_nm_reg |=> {cc_reg[npic_pkg::CC_I1],
         cc_reg[npic_pkg::CC_I0]} == $past(ispr_flat[2*sel_idx_reg+:2]);
   endproperty
   a_entry_lvl: assert property (p_entry_lvl)
      else $error("entry level differs from vector field");

   property p_nm_lvl;
      @(posedge pclk) disable iff (!presetn)
      entry && sel_nm_reg |=> cc_reg[npic_pkg::CC_I1] &&
         cc_reg[npic_pkg::CC_I0] && !trap_reg;
   endproperty
   a_nm_lvl: assert property (p_nm_lvl)
      else $error("trap entry did not set level 3");

   property p_boundary;
      @(posedge pclk) disable iff (!presetn)
      state_reg == npic_pkg::ST_RUN ##1 state_reg == npic_pkg::ST_STACK
         |-> $past(core_i.instr_end);
   endproperty
   a_boundary: assert property (p_boundary)
      else $error("service began inside an instruction");

   property p_stack_first;
      @(posedge pclk) disable iff (!presetn)
      $rose(entry) |-> $past(state_reg == npic_pkg::ST_STACK &&
                              core_i.stack_ack);
   endproperty
   a_stack_first: assert property (p_stack_first)
      else $error("vector taken without stacking");

   property p_l0_ignored;
      @(posedge pclk) disable iff (!presetn)
      wr_en && paddr == npic_pkg::ADDR_ISPR0 &&
         pwdata[1:0] == npic_pkg::PRIO_L0
         |=> ispr_reg[0][1:0] == $past(ispr_reg[0][1:0]);
   endproperty
   a_l0_ignored: assert property (p_l0_ignored)
      else $error("level 0 code was stored");

   property p_sim;
      @(posedge pclk) disable iff (!presetn)
      core_i.sim && !core_i.cc_wr && !entry |=>
         cc_reg[npic_pkg::CC_I1] && cc_reg[npic_pkg::CC_I0];
   endproperty
   a_sim: assert property (p_sim)
      else $error("mask-all did not set level 3");

   property p_pop;
      @(posedge pclk) disable iff (!presetn)
      core_i.cc_wr && !entry |=>
         cc_reg == ($past(core_i.cc_wdata) | npic_pkg::CC_FIXED);
   endproperty
   a_pop: assert property (p_pop)
      else $error("popped cc not restored");

   property p_halt_pick;
      @(posedge pclk) disable iff (!presetn)
      state_reg == npic_pkg::ST_HALT ##1 state_reg == npic_pkg::ST_STACK
         |-> sel_nm_reg || HWM[sel_idx_reg];
   endproperty
   a_halt_pick: assert property (p_halt_pick)
      else $error("non halt-capable source served first after halt");

   property p_wait_wake;
      @(posedge pclk) disable iff (!presetn)
      state_reg == npic_pkg::ST_WAIT && pend_reg != '0 && cur_lvl == 2'b00
         |=> state_reg == npic_pkg::ST_STACK;
   endproperty
   a_wait_wake: assert property (p_wait_wake)
      else $error("pending request did not end wait");

   property p_prio;
      @(posedge pclk) disable iff (!presetn)
      win_found |-> win_lvl > cur_lvl && elig[win_idx];
   endproperty
   a_prio: assert property (p_prio)
      else $error("winner not above current level");
endmodule : npic_ctrl
`default_nettype wire

//--- hdl/npic_pkg.sv
// constants, types and helpers of the nested priority interrupt controller
// assumes an 8-bit core that stacks context on request and fetches vectors
package npic_pkg;
   localparam int NUM_VEC   = 14;
   localparam int EXT_LINES = 4;
   localparam int EXT_PINS  = 4;
   localparam int EXT_BASE  = 2;
   // register byte offsets
   localparam logic [7:0] ADDR_ISPR0 = 8'h00;
   localparam logic [7:0] ADDR_ISPR1 = 8'h04;
   localparam logic [7:0] ADDR_ISPR2 = 8'h08;
   localparam logic [7:0] ADDR_ISPR3 = 8'h0C;
   localparam logic [7:0] ADDR_SENS  = 8'h10;
   localparam logic [7:0] ADDR_CC    = 8'h14;
   localparam logic [7:0] ADDR_PEND  = 8'h18;
   // reset values and fixed bits
   localparam logic [7:0] ISPR_RST   = 8'hFF;
   localparam logic [7:0] ISPR3_RO   = 8'hF0;
   localparam logic [7:0] SENS_RST   = 8'h00;
   localparam logic [7:0] CC_RST     = 8'hEA;
   localparam logic [7:0] CC_FIXED   = 8'hC0;
   localparam int         CC_I1      = 5;
   localparam int         CC_I0      = 3;
   // priority codes {i1,i0}
   localparam logic [1:0] PRIO_L0    = 2'b10;
   localparam logic [1:0] PRIO_L3    = 2'b11;
   // vectors
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
   localparam logic [15:0] VEC_BASE  = 16'hFFFA;
   localparam logic [13:0] HALT_WAKE = 14'h00BE;
   // external sensitivity codes
   localparam logic [1:0] SENS_FLOW  = 2'b00;
   localparam logic [1:0] SENS_RISE  = 2'b01;
   localparam logic [1:0] SENS_FALL  = 2'b10;
   localparam logic [1:0] SENS_BOTH  = 2'b11;

   typedef enum logic [5:0] {
      ST_RSTV  = 6'b000001,
      ST_RUN   = 6'b000010,
      ST_HALT  = 6'b000100,
      ST_WAIT  = 6'b001000,
      ST_STACK = 6'b010000,
      ST_VECT  = 6'b100000
   } npic_state_t;

   typedef struct packed {
      logic       instr_end;
      logic       stack_ack;
      logic       trap;
      logic       irq_enable_instr;
      logic       sim;
      logic       halt;
      logic       wait_for_irq_instr;
      logic       cc_wr;
      logic [7:0] cc_wdata;
   } npic_core_in_t;

   typedef struct packed {
      logic        stack_req;
      logic        vec_load;
      logic [15:0] vec_addr;
      logic        halted;
      logic        waiting;
      logic [7:0]  cc;
   } npic_core_out_t;

   // priority code to level 0..3
   function automatic logic [1:0] npic_lvl(input logic [1:0] code);
      npic_lvl = {~(code[1] ^ code[0]), code[0]};
   endfunction : npic_lvl
endpackage : npic_pkg
